// ==== logic/gwp_pin_logic.sv ====
// Pin logic of the fieldbus gateway: shift register port, straps, indicators, serial port
// Operation
// - Rising output latch strobe follows shifted bits
// - Output data leaves most significant bit first
// - Input latch strobe captures before shifting in
// - One shift clock times both directions
// - Boot strap low at start: update mode
// - Setup strap low at start: configuration mode
// - Service button press requests network announcement; the code sees a press only while the indicator is not driving the pin
// - Indicator on without application code
// - Indicator blinks half hertz without configuration
// - Indicator off when fully configured
// - Lamp flashes on button or wink; the code sees the button only while the indicator is not driving the pin
// - Lamp steady after addressed data exchange
// - Driver enable high whole transmit frame
// - Serial rate programmable 110 to 625k baud
// - Serial port carries setup or update traffic
// - Shift port and serial port run concurrently
// - Up to 256 bits, separate lengths
// - Shift clock at least 150 kHz
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "gwp_defs.svh"
module gwp_pin_logic #(
   parameter int BLINK_HALF_CYC = (`GWP_BLINK_PERIOD_MS / 2) * (`GWP_SYS_CLK_HZ / 1000),
   parameter int FLASH_HALF_CYC = (`GWP_FLASH_PERIOD_MS / 2) * (`GWP_SYS_CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register port
   input wire gwp_pkg::gwp_addr_t ADDR,
   input wire gwp_pkg::gwp_word_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output var gwp_pkg::gwp_word_t RDATA,
   // Shift register port
   output var logic SCK,
   output var logic DOUT,
   input wire logic DIN,
   output var logic LOAD_IN,
   output var logic LOAD_OUT,
   // Start-up straps and captured modes
   input wire logic BOOT_STRAP_N,
   input wire logic SETUP_STRAP_N,
   output var logic BOOT_MODE,
   output var logic SETUP_MODE,
   // Service pin, open drain
   input wire logic SVC_I,
   output var logic SVC_O,
   output var logic SVC_OE,
   // Bus activity lamp
   output var logic BUS_ACTIVITY_LAMP,
   // Asynchronous serial port
   output var logic TXD,
   input wire logic RXD,
   output var logic DRIVER_ENABLE_LINE
);
   import gwp_pkg::*;

   localparam int SR_HALF = `GWP_SR_HALF;
   // Longest legal shift clock half period; a slower clock would starve the chips' users
   localparam int SCK_HALF_MAX = `GWP_SYS_CLK_HZ / (2 * `GWP_SCK_MIN_HZ);

   gwp_st_t st;
   gwp_st_t nx;
   gwp_byte_t out_rd;
   gwp_byte_t in_rd;
   gwp_len_t nbits;
   logic half_end;
   logic pressed;
   logic start_sr;
   logic [`GWP_BAUD_W-1:0] rx_thr;

   // Helper terms of the current state
   assign nbits = (st.out_len > st.in_len) ? st.out_len : st.in_len;
   assign half_end = (st.sr_div == 7'(SR_HALF - 1));
   assign pressed = !st.sync2[`GWP_SY_SVC] && !st.svc_oe;
   assign start_sr = WR && (ADDR == `GWP_OFS_CTRL) && WDATA[`GWP_CTRL_START]
                     && (st.sr_state == SR_IDLE);
   assign rx_thr = (st.rx_bit == '0) ? {1'b0, st.baud_div[`GWP_BAUD_W-1:1]} : st.baud_div;

   // Output bytes: software writes, the shifter reads
   gwp_byte_mem u_out_mem (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .we(st.ow_we),
      .wa(st.ow_addr),
      .wd(st.ow_data),
      .ra(st.sr_bit[`GWP_LEN_W-2:3]),
      .rd(out_rd)
   );

   // Input bytes: the shifter writes, software reads at the next pointer value
   gwp_byte_mem u_in_mem (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .we(st.iw_we),
      .wa(st.iw_addr),
      .wd(st.iw_data),
      .ra(nx.in_ptr),
      .rd(in_rd)
   );

   // Next-state logic of the whole block
   always_comb begin
      nx = st;
      nx.sync1 = {RXD, SVC_I, SETUP_STRAP_N, BOOT_STRAP_N, DIN};
      nx.sync2 = st.sync1;
      nx.ow_we = 1'b0;
      nx.iw_we = 1'b0;
      nx.rdata = '0;

      // Straps are taken once, after the synchronisers hold real pin levels
      if (!st.captured) begin
         nx.cap_cnt = st.cap_cnt + 1'b1;
         if (st.cap_cnt == `GWP_CAP_WAIT) begin
            nx.captured = 1'b1;
            nx.boot_mode = !st.sync2[`GWP_SY_BOOT];
            nx.setup_mode = !st.sync2[`GWP_SY_SETUP];
         end
      end

      // Register writes
      if (WR) begin
         case (ADDR)
            `GWP_OFS_CTRL: begin
               nx.wink = WDATA[`GWP_CTRL_WINK];
               nx.exch = WDATA[`GWP_CTRL_EXCH];
               nx.has_app = WDATA[`GWP_CTRL_HAS_APP];
               nx.has_cfg = WDATA[`GWP_CTRL_HAS_CFG];
            end
            `GWP_OFS_STATUS: begin
               if (WDATA[`GWP_STAT_SVC_REQ]) nx.svc_req = 1'b0;
            end
            `GWP_OFS_OUT_LEN: begin
               nx.out_len = (WDATA[`GWP_LEN_W-1:0] > `GWP_LEN_MAX) ? `GWP_LEN_MAX
                            : WDATA[`GWP_LEN_W-1:0];
            end
            `GWP_OFS_IN_LEN: begin
               nx.in_len = (WDATA[`GWP_LEN_W-1:0] > `GWP_LEN_MAX) ? `GWP_LEN_MAX
                           : WDATA[`GWP_LEN_W-1:0];
            end
            `GWP_OFS_OUT_DATA: begin
               nx.ow_we = 1'b1;
               nx.ow_addr = st.out_ptr;
               nx.ow_data = WDATA[`GWP_BYTE_W-1:0];
               nx.out_ptr = st.out_ptr + 1'b1;
            end
            `GWP_OFS_OUT_PTR: nx.out_ptr = WDATA[`GWP_MEM_AW-1:0];
            `GWP_OFS_IN_PTR: nx.in_ptr = WDATA[`GWP_MEM_AW-1:0];
            `GWP_OFS_BAUD: nx.baud_div = WDATA[`GWP_BAUD_W-1:0];
            default: begin
            end
         endcase
      end

      // Register reads, with their side effects
      if (RD) begin
         case (ADDR)
            `GWP_OFS_CTRL: begin
               nx.rdata[`GWP_CTRL_WINK] = st.wink;
               nx.rdata[`GWP_CTRL_EXCH] = st.exch;
               nx.rdata[`GWP_CTRL_HAS_APP] = st.has_app;
               nx.rdata[`GWP_CTRL_HAS_CFG] = st.has_cfg;
            end
            `GWP_OFS_STATUS: begin
               nx.rdata[`GWP_STAT_SR_BUSY] = (st.sr_state != SR_IDLE);
               nx.rdata[`GWP_STAT_TX_BUSY] = st.tx_busy;
               nx.rdata[`GWP_STAT_RX_VALID] = st.rx_valid;
               nx.rdata[`GWP_STAT_SVC_REQ] = st.svc_req;
               nx.rdata[`GWP_STAT_BOOT] = st.boot_mode;
               nx.rdata[`GWP_STAT_SETUP] = st.setup_mode;
            end
            `GWP_OFS_OUT_LEN: nx.rdata[`GWP_LEN_W-1:0] = st.out_len;
            `GWP_OFS_IN_LEN: nx.rdata[`GWP_LEN_W-1:0] = st.in_len;
            `GWP_OFS_OUT_PTR: nx.rdata[`GWP_MEM_AW-1:0] = st.out_ptr;
            `GWP_OFS_IN_PTR: nx.rdata[`GWP_MEM_AW-1:0] = st.in_ptr;
            `GWP_OFS_IN_DATA: begin
               nx.rdata[`GWP_BYTE_W-1:0] = in_rd;
               nx.in_ptr = st.in_ptr + 1'b1;
            end
            `GWP_OFS_BAUD: nx.rdata[`GWP_BAUD_W-1:0] = st.baud_div;
            `GWP_OFS_RX_DATA: begin
               nx.rdata[`GWP_BYTE_W-1:0] = st.rx_data;
               nx.rx_valid = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // Shifter: divider runs in every busy state and wraps each half period
      if (st.sr_state != SR_IDLE) begin
         nx.sr_div = half_end ? '0 : st.sr_div + 1'b1;
      end
      case (st.sr_state)
         SR_IDLE: begin
            if (start_sr) begin
               nx.sr_state = SR_LOAD;
               nx.sr_div = '0;
               nx.sr_bit = '0;
               nx.in_acc = '0;
               nx.ld_in = 1'b0;
            end
         end
         SR_LOAD: begin
            if (half_end) begin
               nx.ld_in = 1'b1;
               nx.sr_state = (nbits == '0) ? SR_IDLE : SR_LOW;
            end
         end
         SR_LOW: begin
            // Place the bit well before the rising edge; memory data settled by now
            if (st.sr_div == `GWP_DOUT_AT) begin
               nx.dout = (st.sr_bit < st.out_len) ? out_rd[~st.sr_bit[2:0]] : 1'b0;
            end
            if (half_end) begin
               if (st.sr_bit < st.in_len) begin
                  nx.in_acc = {st.in_acc[`GWP_BYTE_W-2:0], st.sync2[`GWP_SY_DIN]};
                  if ((&st.sr_bit[2:0]) || (st.sr_bit == st.in_len - 1'b1)) begin
                     nx.iw_we = 1'b1;
                     nx.iw_addr = st.sr_bit[`GWP_LEN_W-2:3];
                     nx.iw_data = nx.in_acc;
                  end
               end
               nx.sck = 1'b1;
               nx.sr_state = SR_HIGH;
            end
         end
         SR_HIGH: begin
            if (half_end) begin
               nx.sck = 1'b0;
               if (st.sr_bit == nbits - 1'b1) begin
                  nx.ld_out = 1'b1;
                  nx.sr_state = SR_LATCH;
               end else begin
                  nx.sr_bit = st.sr_bit + 1'b1;
                  nx.sr_state = SR_LOW;
               end
            end
         end
         SR_LATCH: begin
            if (half_end) begin
               nx.ld_out = 1'b0;
               nx.sr_state = SR_IDLE;
            end
         end
         default: nx.sr_state = SR_IDLE;
      endcase

      // Service button: a press is only visible while the pin is not driven
      nx.svc_prev = pressed;
      if (pressed && !st.svc_prev) nx.svc_req = 1'b1;
      if (st.blink_cnt == 27'(BLINK_HALF_CYC - 1)) begin
         nx.blink_cnt = '0;
         nx.blink_ph = !st.blink_ph;
      end else begin
         nx.blink_cnt = st.blink_cnt + 1'b1;
      end
      if (!st.has_app) nx.svc_oe = 1'b1;
      else if (!st.has_cfg) nx.svc_oe = st.blink_ph;
      else nx.svc_oe = 1'b0;

      // Bus activity lamp: flashing outranks the steady state
      if (st.flash_cnt == 27'(FLASH_HALF_CYC - 1)) begin
         nx.flash_cnt = '0;
         nx.flash_ph = !st.flash_ph;
      end else begin
         nx.flash_cnt = st.flash_cnt + 1'b1;
      end
      if (pressed || st.wink) nx.lamp = st.flash_ph;
      else nx.lamp = st.exch;

      // Transmitter, independent of the shifter; enable spans start to stop bit
      if (WR && (ADDR == `GWP_OFS_TX_DATA) && !st.tx_busy) begin
         nx.tx_busy = 1'b1;
         nx.de = 1'b1;
         nx.tx_sh = {1'b1, WDATA[`GWP_BYTE_W-1:0], 1'b0};
         nx.txd = 1'b0;
         nx.tx_cnt = '0;
         nx.tx_bit = '0;
      end else if (st.tx_busy) begin
         if (st.tx_cnt + 1'b1 >= st.baud_div) begin
            nx.tx_cnt = '0;
            if (st.tx_bit == `GWP_UART_LAST) begin
               nx.tx_busy = 1'b0;
               nx.de = 1'b0;
               nx.txd = 1'b1;
            end else begin
               nx.tx_bit = st.tx_bit + 1'b1;
               nx.tx_sh = {1'b1, st.tx_sh[9:1]};
               nx.txd = st.tx_sh[1];
            end
         end else begin
            nx.tx_cnt = st.tx_cnt + 1'b1;
         end
      end

      // Receiver: samples mid-bit, drops false starts and bad stop bits
      if (!st.rx_busy) begin
         if (!st.sync2[`GWP_SY_RXD]) begin
            nx.rx_busy = 1'b1;
            nx.rx_cnt = '0;
            nx.rx_bit = '0;
         end
      end else if (st.rx_cnt + 1'b1 >= rx_thr) begin
         nx.rx_cnt = '0;
         nx.rx_bit = st.rx_bit + 1'b1;
         if ((st.rx_bit == '0) && st.sync2[`GWP_SY_RXD]) begin
            nx.rx_busy = 1'b0;
         end else if (st.rx_bit == `GWP_UART_LAST) begin
            nx.rx_busy = 1'b0;
            if (st.sync2[`GWP_SY_RXD]) begin
               nx.rx_data = st.rx_sh;
               nx.rx_valid = 1'b1;
            end
         end else if (st.rx_bit != '0) begin
            nx.rx_sh = {st.sync2[`GWP_SY_RXD], st.rx_sh[`GWP_BYTE_W-1:1]};
         end
      end else begin
         nx.rx_cnt = st.rx_cnt + 1'b1;
      end
   end

   // State register; idle levels are high on the input load strobe, serial line and synchronisers, low on the output latch strobe
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st <= '0;
         st.sync1 <= `GWP_SYNC_RST;
         st.sync2 <= `GWP_SYNC_RST;
         st.ld_in <= 1'b1;
         st.txd <= 1'b1;
         st.baud_div <= `GWP_BAUD_RST;
         st.sr_state <= SR_IDLE;
      end else begin
         st <= nx;
      end
   end

   // Every output comes from the state register
   assign RDATA = st.rdata;
   assign SCK = st.sck;
   assign DOUT = st.dout;
   assign LOAD_IN = st.ld_in;
   assign LOAD_OUT = st.ld_out;
   assign BOOT_MODE = st.boot_mode;
   assign SETUP_MODE = st.setup_mode;
   assign SVC_O = st.svc_o;
   assign SVC_OE = st.svc_oe;
   assign BUS_ACTIVITY_LAMP = st.lamp;
   assign TXD = st.txd;
   assign DRIVER_ENABLE_LINE = st.de;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_load_low;
      (!st.ld_in && !st.sck)[*8];
   endsequence
   sequence s_clock_high;
      (st.sck && !st.ld_out)[*8];
   endsequence

   property p_load_before_shift;
      $fell(st.ld_in) |-> s_load_low;
   endproperty
   a_load_before_shift: assert property (p_load_before_shift) else $error("load strobe short");
   property p_latch_after_last;
      $rose(st.ld_out) |-> !st.sck && $past(st.sr_state) == SR_HIGH
                           && $past(st.sr_bit) == $past(nbits) - 1'b1;
   endproperty
   a_latch_after_last: assert property (p_latch_after_last) else $error("early latch");
   property p_msb_first;
      (st.sr_state == SR_LOW && st.sr_div == `GWP_DOUT_AT + 7'h01 && st.sr_bit < st.out_len)
         |-> st.dout == out_rd[~st.sr_bit[2:0]];
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("output bit order wrong");
   property p_clock_high;
      $rose(st.sck) |-> s_clock_high ##[1:SCK_HALF_MAX] !st.sck;
   endproperty
   a_clock_high: assert property (p_clock_high) else $error("shift clock high phase wrong");
   property p_sck_quiet;
      st.sr_state == SR_IDLE |-> !st.sck && !st.ld_out && st.ld_in;
   endproperty
   a_sck_quiet: assert property (p_sck_quiet) else $error("shift lines active when idle");
   property p_boot_cap;
      $rose(st.captured) |-> st.boot_mode == !$past(st.sync2[`GWP_SY_BOOT]);
   endproperty
   a_boot_cap: assert property (p_boot_cap) else $error("boot strap missed");
   property p_setup_cap;
      $rose(st.captured) |-> st.setup_mode == !$past(st.sync2[`GWP_SY_SETUP]);
   endproperty
   a_setup_cap: assert property (p_setup_cap) else $error("setup strap missed");
   property p_svc_req;
      (pressed && !st.svc_prev) |=> st.svc_req;
   endproperty
   a_svc_req: assert property (p_svc_req) else $error("service press lost");
   property p_led_on;
      !st.has_app |=> st.svc_oe;
   endproperty
   a_led_on: assert property (p_led_on) else $error("indicator not on");
   property p_led_blink;
      (st.has_app && !st.has_cfg) |=> st.svc_oe == $past(st.blink_ph);
   endproperty
   a_led_blink: assert property (p_led_blink) else $error("indicator not blinking");
   property p_led_off;
      (st.has_app && st.has_cfg) |=> !st.svc_oe;
   endproperty
   a_led_off: assert property (p_led_off) else $error("indicator not off");
   property p_lamp_flash;
      (pressed || st.wink) |=> st.lamp == $past(st.flash_ph);
   endproperty
   a_lamp_flash: assert property (p_lamp_flash) else $error("lamp not flashing");
   property p_lamp_steady;
      (!pressed && !st.wink && st.exch) |=> st.lamp;
   endproperty
   a_lamp_steady: assert property (p_lamp_steady) else $error("lamp not steady");
   property p_de_frame;
      (!st.de |-> st.txd) and ($rose(st.de) |-> !st.txd);
   endproperty
   a_de_frame: assert property (p_de_frame) else $error("enable misses frame");

endmodule : gwp_pin_logic
`default_nettype wire

// ==== logic/gwp_defs.svh ====
// Constants shared by the gateway pin logic: clocking, timing, offsets and field positions
`ifndef GWP_DEFS_SVH
`define GWP_DEFS_SVH

// System clock and shift clock rates
`define GWP_SYS_CLK_HZ 100000000
`define GWP_SCK_HZ 1000000
// Slowest shift clock the port may run at
`define GWP_SCK_MIN_HZ 150000
// Cycles per shift clock half period (a minimum rate, so the count rounds down)
`define GWP_SR_HALF (`GWP_SYS_CLK_HZ / (2 * `GWP_SCK_HZ))
// Divider cycle within the low phase at which the next output bit is placed
`define GWP_DOUT_AT 7'h01
// Indicator periods in milliseconds
`define GWP_BLINK_PERIOD_MS 2000
`define GWP_FLASH_PERIOD_MS 500
// Cycles after reset release before the straps are taken
`define GWP_CAP_WAIT 2'h2

// Transfer buffer geometry
`define GWP_BYTE_W 8
`define GWP_MEM_AW 5
`define GWP_MEM_DEPTH 32
`define GWP_LEN_W 9
`define GWP_LEN_MAX 9'h100

// Synchroniser lanes
`define GWP_SYNC_W 5
`define GWP_SYNC_RST 5'h1F
`define GWP_SY_DIN 0
`define GWP_SY_BOOT 1
`define GWP_SY_SETUP 2
`define GWP_SY_SVC 3
`define GWP_SY_RXD 4

// Serial port: default divisor gives 9600 baud, last frame bit index is the stop bit
`define GWP_BAUD_W 20
`define GWP_BAUD_RST 20'h028B0
`define GWP_UART_LAST 4'h9

// Register byte offsets
`define GWP_OFS_CTRL 8'h00
`define GWP_OFS_STATUS 8'h04
`define GWP_OFS_OUT_LEN 8'h08
`define GWP_OFS_IN_LEN 8'h0C
`define GWP_OFS_OUT_DATA 8'h10
`define GWP_OFS_OUT_PTR 8'h14
`define GWP_OFS_IN_DATA 8'h18
`define GWP_OFS_IN_PTR 8'h1C
`define GWP_OFS_BAUD 8'h20
`define GWP_OFS_TX_DATA 8'h24
`define GWP_OFS_RX_DATA 8'h28

// Control register fields
`define GWP_CTRL_START 0
`define GWP_CTRL_WINK 1
`define GWP_CTRL_EXCH 2
`define GWP_CTRL_HAS_APP 3
`define GWP_CTRL_HAS_CFG 4

// Status register fields
`define GWP_STAT_SR_BUSY 0
`define GWP_STAT_TX_BUSY 1
`define GWP_STAT_RX_VALID 2
`define GWP_STAT_SVC_REQ 3
`define GWP_STAT_BOOT 4
`define GWP_STAT_SETUP 5

`endif

// ==== logic/gwp_pkg.sv ====
// Types of the gateway pin logic
`default_nettype none
package gwp_pkg;
`include "gwp_defs.svh"

   typedef logic [7:0] gwp_addr_t;
   typedef logic [31:0] gwp_word_t;
   typedef logic [`GWP_BYTE_W-1:0] gwp_byte_t;
   typedef logic [`GWP_MEM_AW-1:0] gwp_ptr_t;
   typedef logic [`GWP_LEN_W-1:0] gwp_len_t;

   typedef enum logic [2:0] {SR_IDLE, SR_LOAD, SR_LOW, SR_HIGH, SR_LATCH} gwp_sr_state_t;

   typedef struct packed {
      gwp_byte_t [`GWP_MEM_DEPTH-1:0] cells;
      gwp_byte_t rd;
   } gwp_mem_st_t;

   typedef struct packed {
      logic [`GWP_SYNC_W-1:0] sync1;
      logic [`GWP_SYNC_W-1:0] sync2;
      logic [1:0] cap_cnt;
      logic captured;
      logic boot_mode;
      logic setup_mode;
      logic wink;
      logic exch;
      logic has_app;
      logic has_cfg;
      gwp_len_t out_len;
      gwp_len_t in_len;
      gwp_ptr_t out_ptr;
      gwp_ptr_t in_ptr;
      logic ow_we;
      gwp_ptr_t ow_addr;
      gwp_byte_t ow_data;
      gwp_sr_state_t sr_state;
      logic [6:0] sr_div;
      gwp_len_t sr_bit;
      gwp_byte_t in_acc;
      logic iw_we;
      gwp_ptr_t iw_addr;
      gwp_byte_t iw_data;
      logic sck;
      logic dout;
      logic ld_in;
      logic ld_out;
      logic svc_prev;
      logic svc_req;
      logic svc_oe;
      logic svc_o;
      logic [26:0] blink_cnt;
      logic blink_ph;
      logic [26:0] flash_cnt;
      logic flash_ph;
      logic lamp;
      logic [`GWP_BAUD_W-1:0] baud_div;
      logic tx_busy;
      logic txd;
      logic de;
      logic [`GWP_BAUD_W-1:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic rx_busy;
      logic [`GWP_BAUD_W-1:0] rx_cnt;
      logic [3:0] rx_bit;
      gwp_byte_t rx_sh;
      gwp_byte_t rx_data;
      logic rx_valid;
      gwp_word_t rdata;
   } gwp_st_t;

endpackage : gwp_pkg
`default_nettype wire

// ==== logic/gwp_byte_mem.sv ====
// Byte-wide transfer buffer with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module gwp_byte_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write port
   input wire logic we,
   input wire gwp_pkg::gwp_ptr_t wa,
   input wire gwp_pkg::gwp_byte_t wd,
   // Read port
   input wire gwp_pkg::gwp_ptr_t ra,
   output var gwp_pkg::gwp_byte_t rd
);
   import gwp_pkg::*;

   gwp_mem_st_t st;
   gwp_mem_st_t nx;

   // Read returns the old contents when a write hits the same cell
   always_comb begin
      nx = st;
      if (we) begin
         nx.cells[wa] = wd;
      end
      nx.rd = st.cells[ra];
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign rd = st.rd;

endmodule : gwp_byte_mem
`default_nettype wire

// ==== tb/gwp_sr_chips.sv ====
// Behavioural model of the external shift register chips on the synchronous port
`timescale 1ns/10ps
`default_nettype none
module gwp_sr_chips #(
   parameter int W = 16
) (
   // Shift port pins
   input wire logic sck,
   input wire logic dout,
   input wire logic load_in_n,
   input wire logic load_out,
   output var logic din,
   // Parallel sides
   input wire logic [W-1:0] par_in,
   output var logic [W-1:0] par_out
);
   logic [W-1:0] sh_in = '0;
   logic [W-1:0] sh_out = '0;
   int rises = 0;
   int latches = 0;
   // Input chip: low load captures, MSB shown first, next bit after each rise
   always @(negedge load_in_n or posedge sck) begin
      if (!load_in_n) sh_in <= par_in;
      else sh_in <= {sh_in[W-2:0], 1'b1};
   end
   always_comb din = sh_in[W-1];
   // Output chip: shift on the same clock, parallel outputs move only on latch rise
   always @(posedge sck) begin
      sh_out <= {sh_out[W-2:0], dout};
      rises++;
   end
   always @(posedge load_out) begin
      par_out <= sh_out;
      latches++;
   end
endmodule : gwp_sr_chips
`default_nettype wire

// ==== tb/gwp_pin_logic_tb.sv ====
// Self-checking bench of the gateway pin logic with shift register chips and serial loopback
`timescale 1ns/10ps
`default_nettype none
`include "gwp_defs.svh"
module gwp_pin_logic_tb;
   import gwp_pkg::*;
   localparam int BAUD = 160;
   logic sys_clk = 0;
   logic sys_rst = 1;
   logic wr_s = 0;
   logic rd_s = 0;
   gwp_addr_t addr = '0;
   gwp_word_t wdata = '0;
   gwp_word_t rdata;
   gwp_word_t d;
   logic sck, dout, din, load_in, load_out, boot_mode, setup_mode, svc_o, svc_oe, lamp, txd, de;
   logic boot_n = 1;
   logic setup_n = 1;
   logic btn = 0;
   logic svc_pin;
   logic [15:0] par_out;
   int num_errors = 0;
   int checked = 0;
   int t;
   // Open-drain service pin: low when the button or the indicator pulls it
   assign svc_pin = (btn || svc_oe) ? 1'b0 : 1'b1;
   gwp_pin_logic #(.BLINK_HALF_CYC(20), .FLASH_HALF_CYC(8)) uut (.SYS_CLK(sys_clk),
      .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .SCK(sck), .DOUT(dout), .DIN(din), .LOAD_IN(load_in), .LOAD_OUT(load_out),
      .BOOT_STRAP_N(boot_n), .SETUP_STRAP_N(setup_n), .BOOT_MODE(boot_mode),
      .SETUP_MODE(setup_mode), .SVC_I(svc_pin), .SVC_O(svc_o), .SVC_OE(svc_oe),
      .BUS_ACTIVITY_LAMP(lamp), .TXD(txd), .RXD(txd), .DRIVER_ENABLE_LINE(de));
   gwp_sr_chips #(.W(16)) chip (.sck(sck), .dout(dout), .load_in_n(load_in),
      .load_out(load_out), .din(din), .par_in(16'hA5C3), .par_out(par_out));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input gwp_word_t got, input gwp_word_t exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   // Bus cycles: one-cycle strobes, read data taken in the cycle after the strobe
   task automatic wr(input gwp_addr_t a, input gwp_word_t v);
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1;
      @(posedge sys_clk);
      wr_s <= 0;
   endtask : wr
   task automatic rd(input gwp_addr_t a);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1;
      @(posedge sys_clk);
      rd_s <= 0;
      #1 d = rdata;
   endtask : rd
   // Straps are held through reset and a few edges after it
   // Block reset stands in for the board pin; the pulse is shortened to keep runs brief
   task automatic rst(input logic b, input logic s);
      @(posedge sys_clk);
      boot_n <= b;
      setup_n <= s;
      sys_rst <= 1;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 0;
      repeat (6) @(posedge sys_clk);
      boot_n <= 1;
      setup_n <= 1;
      repeat (3) @(posedge sys_clk);
   endtask : rst
   // Counts changes of the lamp or the indicator over n cycles
   task automatic toggles(input bit sel, input int n, output int c);
      logic p;
      c = 0;
      repeat (n) begin
         p = sel ? lamp : svc_oe;
         @(posedge sys_clk);
         #1 if ((sel ? lamp : svc_oe) !== p) c++;
      end
   endtask : toggles
   task automatic sc_straps;
      rst(1'b0, 1'b1);
      chk(boot_mode, 1);
      chk(setup_mode, 0);
      chk(svc_o, 0);
      rd(`GWP_OFS_STATUS);
      chk(d[5:4], 2'b01);
      rd(`GWP_OFS_BAUD);
      chk(d, `GWP_BAUD_RST);
      rst(1'b1, 1'b0);
      chk(boot_mode, 0);
      chk(setup_mode, 1);
      rd(8'hFC);
      chk(d, 0);
      wr(`GWP_OFS_OUT_LEN, 32'h1FF);
      rd(`GWP_OFS_OUT_LEN);
      chk(d, 32'h100);
   endtask : sc_straps
   // Shift transfer and serial frame launched together
   task automatic sc_shift;
      int r0;
      int l0;
      r0 = chip.rises;
      l0 = chip.latches;
      wr(`GWP_OFS_OUT_LEN, 16);
      wr(`GWP_OFS_IN_LEN, 16);
      wr(`GWP_OFS_OUT_PTR, 0);
      wr(`GWP_OFS_OUT_DATA, 32'h58);
      wr(`GWP_OFS_OUT_DATA, 32'h21);
      wr(`GWP_OFS_IN_PTR, 0);
      wr(`GWP_OFS_BAUD, BAUD);
      wr(`GWP_OFS_CTRL, 32'h01);
      wr(`GWP_OFS_TX_DATA, 32'h53);
      t = 0;
      while (txd !== 1'b0 && t < 5) begin
         @(posedge sys_clk);
         #1 t++;
      end
      chk(t < 5, 1);
      t = 0;
      repeat (10 * BAUD - 2) begin
         @(posedge sys_clk);
         #1 if (de !== 1'b1) t++;
      end
      chk(t, 0);
      repeat (6) @(posedge sys_clk);
      #1 chk(de, 0);
      rd(`GWP_OFS_RX_DATA);
      chk(d, 32'h53);
      for (t = 0; t < 40; t++) begin
         rd(`GWP_OFS_STATUS);
         if (d[0] === 1'b0) break;
         repeat (50) @(posedge sys_clk);
      end
      if (t == 40) begin
         num_errors++;
         $display("BAD t=%0t shifter stuck busy", $time);
      end
      chk(par_out, 16'h5821);
      chk(chip.rises - r0, 16);
      chk(chip.latches - l0, 1);
      rd(`GWP_OFS_IN_DATA);
      chk(d, 32'hA5);
      rd(`GWP_OFS_IN_DATA);
      chk(d, 32'hC3);
   endtask : sc_shift
   task automatic sc_ind;
      chk(svc_oe, 1);
      wr(`GWP_OFS_CTRL, 32'h08);
      toggles(0, 50, t);
      chk(t >= 2, 1);
      wr(`GWP_OFS_CTRL, 32'h18);
      repeat (3) @(posedge sys_clk);
      #1 chk(svc_oe, 0);
      @(posedge sys_clk);
      btn <= 1;
      toggles(1, 30, t);
      chk(t >= 2, 1);
      @(posedge sys_clk);
      btn <= 0;
      rd(`GWP_OFS_STATUS);
      chk(d[3], 1);
      wr(`GWP_OFS_STATUS, 32'h08);
      rd(`GWP_OFS_STATUS);
      chk(d[3], 0);
      wr(`GWP_OFS_CTRL, 32'h1C);
      repeat (3) @(posedge sys_clk);
      toggles(1, 30, t);
      chk(t, 0);
      chk(lamp, 1);
      wr(`GWP_OFS_CTRL, 32'h1A);
      toggles(1, 30, t);
      chk(t >= 2, 1);
   endtask : sc_ind
   initial begin
      sc_straps();
      sc_shift();
      sc_ind();
      report_and_stop();
   end
endmodule : gwp_pin_logic_tb
`default_nettype wire
